/* File: verilog/ppc_pin_config.v */
// Purpose: Per-pin configuration for pins 2.3 and 3.0 to 3.3
// Assumes: APB slave, pins synchronous to pclk
// Notes:   Config registers are write-only and read as zero
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"

module ppc_pin_config
(
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        tick_64hz,
    input  wire [4:0]  port_data,
    input  wire        port_data_load,
    input  wire [4:0]  pad_in,
    output reg  [4:0]  pad_out,
    output reg  [4:0]  pad_oe_n,
    output reg  [4:0]  pull_en,
    output reg  [4:0]  ext_irq_level,
    output reg  [4:0]  sample_sel,
    output reg         serial_rx_sel,
    output reg         serial_rx_data,
    output reg         irq
);

    // ------------------------------------------------
    // Address decode
    // ------------------------------------------------
    function [4:0] cfg_hit;
        input [7:0] a;
        begin
            cfg_hit = 5'h00;
            if (a[1:0] == 2'b00)
            begin
                case (a[7:2])
                    `PPC_IDX_PIN23: cfg_hit = 5'h01;
                    `PPC_IDX_PIN30: cfg_hit = 5'h02;
                    `PPC_IDX_PIN31: cfg_hit = 5'h04;
                    `PPC_IDX_PIN32: cfg_hit = 5'h08;
                    `PPC_IDX_PIN33: cfg_hit = 5'h10;
                    default:        cfg_hit = 5'h00;
                endcase
            end
        end
    endfunction

    function own_hit;
        input [7:0] a;
        input [5:0] idx;
        begin
            own_hit = (a == {idx, 2'b00});
        end
    endfunction

    // ------------------------------------------------
    // Bus phases
    // ------------------------------------------------
    wire       access;
    wire       done;
    wire       wr_done;
    wire [4:0] cfg_sel;
    wire       stat_sel;
    wire       mask_sel;
    wire       lvl_sel;
    wire       mapped;

    assign access   = psel & penable;
    assign done     = access & pready;
    assign wr_done  = done & pwrite;
    assign cfg_sel  = cfg_hit(paddr);
    assign stat_sel = own_hit(paddr, `PPC_IDX_STATUS);
    assign mask_sel = own_hit(paddr, `PPC_IDX_MASK);
    assign lvl_sel  = own_hit(paddr, `PPC_IDX_LEVEL);
    assign mapped   = (|cfg_sel) | stat_sel | mask_sel | lvl_sel;

    // ------------------------------------------------
    // Config storage
    // ------------------------------------------------
    reg [3:0] cfg_q [0:`PPC_NPINS-1];
    integer   k;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (k = 0; k < `PPC_NPINS; k = k + 1)
            begin
                cfg_q[k] <= `PPC_CFG_RST;
            end
        end
        else
        begin
            for (k = 0; k < `PPC_NPINS; k = k + 1)
            begin
                if (wr_done && cfg_sel[k])
                begin
                    cfg_q[k] <= pwdata[3:0];
                end
            end
        end
    end

    // ------------------------------------------------
    // Per-pin decode
    // ------------------------------------------------
    wire [4:0] f_ie;
    wire [4:0] f_fsel;
    wire [4:0] f_dir;
    wire [4:0] f_mode;
    wire [4:0] eff_dir;
    wire [4:0] clk_pick;
    wire [4:0] lvl_w;
    wire [4:0] ev_w;
    wire       rx_sel_on;

    assign rx_sel_on = f_fsel[`PPC_PIN33];

    genvar i;
    generate
        for (i = 0; i < `PPC_NPINS; i = i + 1)
        begin : g_pin
            assign f_ie[i]   = cfg_q[i][`PPC_BIT_IE];
            assign f_fsel[i] = cfg_q[i][`PPC_BIT_FSEL];
            assign f_dir[i]  = cfg_q[i][`PPC_BIT_DIR];
            assign f_mode[i] = cfg_q[i][`PPC_BIT_MODE];

            if (i == `PPC_PIN33)
            begin : g_p33
                assign eff_dir[i]  = f_dir[i] & ~rx_sel_on;
                assign clk_pick[i] = 1'b0;
            end
            else
            begin : g_norm
                assign eff_dir[i]  = f_dir[i];
                assign clk_pick[i] = f_fsel[i];
            end

            ppc_pin_sampler u_smp
            (
                .pclk      (pclk),
                .presetn   (presetn),
                .pad_in    (pad_in[i]),
                .tick_64hz (tick_64hz),
                .clk_sel   (clk_pick[i]),
                .irq_en    (f_ie[i]),
                .level_q   (lvl_w[i]),
                .event_q   (ev_w[i])
            );
        end
    endgenerate

    // ------------------------------------------------
    // Port data latch
    // ------------------------------------------------
    reg [4:0] dout_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dout_q <= `PPC_OUT_RST;
        end
        else if (port_data_load)
        begin
            dout_q <= port_data;
        end
    end

    // ------------------------------------------------
    // Pad control
    // ------------------------------------------------
    wire [4:0] drive_d;
    wire [4:0] pull_d;

    // Open drain never drives high
    assign drive_d = eff_dir & (~f_mode | ~dout_q);
    assign pull_d  = ~eff_dir & ~f_mode;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_out        <= `PPC_OUT_RST;
            pad_oe_n       <= 5'h1f;
            pull_en        <= 5'h1f;
        end
        else
        begin
            pad_out        <= dout_q;
            pad_oe_n       <= ~drive_d;
            pull_en        <= pull_d;
        end
    end

    // ------------------------------------------------
    // Sampling and serial outputs
    // ------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_irq_level  <= 5'h00;
            sample_sel     <= 5'h00;
            serial_rx_sel  <= 1'b0;
            serial_rx_data <= 1'b1;
        end
        else
        begin
            ext_irq_level  <= lvl_w;
            sample_sel     <= clk_pick;
            serial_rx_sel  <= rx_sel_on;
            // Idle high while pin 3.3 is a plain port pin
            serial_rx_data <= rx_sel_on ? pad_in[`PPC_PIN33] : 1'b1;
        end
    end

    // ------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------
    reg  [4:0] stat_q;
    reg  [4:0] mask_q;
    wire [4:0] w1c;
    wire [4:0] stat_d;

    assign w1c    = (wr_done && stat_sel) ? pwdata[4:0] : 5'h00;
    // A new event wins over a clear in the same cycle
    assign stat_d = (stat_q & ~w1c) | ev_w;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q <= `PPC_STAT_RST;
        end
        else
        begin
            stat_q <= stat_d;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mask_q <= `PPC_MASK_RST;
        end
        else if (wr_done && mask_sel)
        begin
            mask_q <= pwdata[4:0];
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(stat_q & mask_q);
        end
    end

    // ------------------------------------------------
    // Read data and response
    // ------------------------------------------------
    reg [31:0] rd_d;

    always @*
    begin
        rd_d = 32'h0000_0000;
        if (stat_sel)
        begin
            rd_d = {27'h0000000, stat_q};
        end
        else if (mask_sel)
        begin
            rd_d = {27'h0000000, mask_q};
        end
        else if (lvl_sel)
        begin
            rd_d = {27'h0000000, ext_irq_level};
        end
        else
        begin
            // Config registers hold nothing readable
            rd_d = 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            // One wait state, answer on the second access cycle
            pready <= access & ~pready;
        end
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (access && !pready)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr <= ~mapped;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/ppc_defines.vh */
// Purpose: Constants for the pin configuration block
// Assumes: APB byte address is four times the register index
// Notes:   Definitions only
`ifndef PPC_DEFINES_VH
`define PPC_DEFINES_VH

// ------------------------------------------------
// Sizes
// ------------------------------------------------
`define PPC_NPINS       5
`define PPC_CFG_W       4
`define PPC_IDX_W       6

// ------------------------------------------------
// Register indices
// ------------------------------------------------
`define PPC_IDX_PIN23   6'h13
`define PPC_IDX_PIN30   6'h14
`define PPC_IDX_PIN31   6'h15
`define PPC_IDX_PIN32   6'h16
`define PPC_IDX_PIN33   6'h17
`define PPC_IDX_STATUS  6'h20
`define PPC_IDX_MASK    6'h21
`define PPC_IDX_LEVEL   6'h22

// ------------------------------------------------
// Config fields and pin 3.3 index
// ------------------------------------------------
`define PPC_BIT_MODE    0
`define PPC_BIT_DIR     1
`define PPC_BIT_FSEL    2
`define PPC_BIT_IE      3
`define PPC_PIN33       4

// ------------------------------------------------
// Reset values
// ------------------------------------------------
`define PPC_CFG_RST     4'h0
`define PPC_STAT_RST    5'h00
`define PPC_MASK_RST    5'h00
`define PPC_OUT_RST     5'h00

// ------------------------------------------------
// Timing
// ------------------------------------------------
`define PPC_SLOW_HZ     64

`endif

/* File: verilog/ppc_pin_sampler.v */
// Purpose: Samples one pin for external interrupt detection
// Assumes: tick_64hz is a one-cycle pulse at the slow rate
// Notes:   Event pulses when the gated level changes
`timescale 1ns/1ps
`default_nettype none

module ppc_pin_sampler
(
    input  wire pclk,
    input  wire presetn,
    input  wire pad_in,
    input  wire tick_64hz,
    input  wire clk_sel,
    input  wire irq_en,
    output reg  level_q,
    output reg  event_q
);

    // ------------------------------------------------
    // Sampling
    // ------------------------------------------------
    reg  sample_q;
    wire take;
    wire level_d;

    assign take    = clk_sel | tick_64hz;
    assign level_d = irq_en & sample_q;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_q <= 1'b0;
            level_q  <= 1'b0;
            event_q  <= 1'b0;
        end
        else
        begin
            if (take)
            begin
                sample_q <= pad_in;
            end
            level_q <= level_d;
            event_q <= level_d ^ level_q;
        end
    end

endmodule

`default_nettype wire

/* File: verification/ppc_pad_model.sv */
// Purpose: Pad model for the pin config block
// Assumes: Pull resistors pull towards PULL_LVL
// Notes:   A pad nobody drives or pulls toggles every cycle
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_model
#(
    parameter PULL_LVL = 1'b0
)
(
    input  wire logic       pclk,
    input  wire logic [4:0] pad_out,
    input  wire logic [4:0] pad_oe_n,
    input  wire logic [4:0] pull_en,
    input  wire logic [4:0] ext_val,
    input  wire logic [4:0] ext_en,
    output var  logic [4:0] pad_in
);
// ----------------
// Pad level
// ----------------
    logic [4:0] flt_q = 5'h15;
    logic [4:0] off;
    always @(posedge pclk)
        flt_q <= ~flt_q;
    assign off = pad_oe_n & ~ext_en;
    // Driver first, then far side, then pull
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
                  | (off & pull_en & {5{PULL_LVL}}) | (off & ~pull_en & flt_q);
endmodule
`default_nettype wire

/* File: verification/ppc_asserts.sv */
// Purpose: Port checks for the pin config block
// Assumes: One pclk domain, async active-low reset
// Notes:   Bound to ppc_pin_config
`timescale 1ns/1ps
`default_nettype none
module ppc_asserts
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        tick_64hz,
    input wire logic        port_data_load,
    input wire logic [4:0]  pad_out,
    input wire logic [4:0]  pad_oe_n,
    input wire logic [4:0]  pull_en,
    input wire logic [4:0]  ext_irq_level,
    input wire logic [4:0]  sample_sel,
    input wire logic        serial_rx_sel,
    input wire logic        serial_rx_data,
    input wire logic        irq
);
// ----------------
// Checks
// ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_wait_state:
        assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    a_ready_pulse:
        assert property (pready |=> !pready) else $error("pready held");
    a_err_ready:
        assert property (pslverr |-> pready) else $error("lone pslverr");
    a_cfg_rd_zero:
        assert property (pready && !pwrite && paddr >= 8'h4c
            && paddr <= 8'h5c |-> prdata == 32'h0) else $error("cfg read");
    a_pull_input:
        assert property ((pull_en & ~pad_oe_n) == 5'h00)
        else $error("pull on driven pin");
    a_no_fsel_33:
        assert property (!sample_sel[4]) else $error("pin33 fsel");
    a_serial_in:
        assert property (serial_rx_sel |-> pad_oe_n[4])
        else $error("pin33 driven");
    a_rx_idle:
        assert property (!serial_rx_sel |-> serial_rx_data)
        else $error("rx not idle");
    a_pad_hold:
        assert property (!port_data_load [*2] |=> $stable(pad_out))
        else $error("pad_out moved");
    a_level_hold:
        assert property ((!tick_64hz && sample_sel == 5'h00 && !psel) [*4]
            |=> $stable(ext_irq_level)) else $error("level moved");
    c_read: cover property (pready && !pwrite);
    c_irq: cover property ($rose(irq));
    c_serial: cover property (serial_rx_sel);
endmodule
bind ppc_pin_config ppc_asserts u_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .tick_64hz,
    .port_data_load, .pad_out, .pad_oe_n, .pull_en, .ext_irq_level,
    .sample_sel, .serial_rx_sel, .serial_rx_data, .irq);
`default_nettype wire

/* File: verification/ppc_testbench.sv */
// Purpose: Self-checking bench for ppc_pin_config
// Assumes: Outputs are sampled at rising edges, before updates land
// Notes:   Read results are scored from a queue
`timescale 1ns/1ps
`default_nettype none
`include "ppc_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    errors++; $display("BAD %s exp %h got %h", n, e, g); end end
`define ADR(k) 8'({(k), 2'b00})
module testbench;
// ----------------
// Bench
// ----------------
    logic        pclk = 1'b0, presetn = 1'b0, tick_64hz = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, port_data_load = 1'b0;
    logic [4:0]  port_data = 5'h00, ext_val = 5'h00, ext_en = 5'h00;
    logic [4:0]  pad_in, pad_out, pad_oe_n, pull_en;
    logic [4:0]  ext_irq_level, sample_sel;
    logic        serial_rx_sel, serial_rx_data, irq;
    logic [32:0] exp_q[$], got_e;
    int          errors = 0, check_count = 0;
    always #10 pclk = ~pclk;
    ppc_pin_config DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tick_64hz, .port_data,
        .port_data_load, .pad_in, .pad_out, .pad_oe_n, .pull_en,
        .ext_irq_level, .sample_sel, .serial_rx_sel, .serial_rx_data, .irq);
    ppc_pad_model u_pads (.pclk, .pad_out, .pad_oe_n, .pull_en, .ext_val,
        .ext_en, .pad_in);
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            got_e = exp_q.pop_front();
            `CHK("read", got_e, {pslverr, prdata})
        end
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        int n;
        n = 0;
        if (!w)
            exp_q.push_back(e);
        // Whole words only
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        // Wait limit ran out
        if (pready !== 1'b1)
            errors++;
        {psel, penable} <= 2'b00;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        apb(1'b0, a, 32'h0, e);
    endtask
    task automatic do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("reset", {5'h00, 5'h1f, 5'h1f, 13'h0002}, {pad_out, pad_oe_n,
            pull_en, ext_irq_level, sample_sel, serial_rx_sel,
            serial_rx_data, irq})
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #1000000;
        errors++;
        conclude();
    end
    initial
    begin
        logic [3:0] cf;
        logic [4:0] pd;
        logic       dir;
        void'($urandom(62));
        do_reset();
        for (int i = 0; i < 5; i++)
            for (int c = 0; c < 16; c++)
            begin
                cf = 4'(c);
                pd = 5'($urandom);
                wr(`ADR(`PPC_IDX_PIN23 + i), {28'h0, cf});
                port_data <= pd;
                port_data_load <= 1'b1;
                @(posedge pclk);
                port_data_load <= 1'b0;
                repeat (2) @(posedge pclk);
                dir = cf[1] & ~(i == 4 && cf[2]);
                `CHK("oe_n", ~(dir & (~cf[0] | ~pd[i])), pad_oe_n[i])
                `CHK("pull", ~dir & ~cf[0], pull_en[i])
                `CHK("out", pd[i], pad_out[i])
                `CHK("fsel", cf[2] & (i < 4), sample_sel[i])
                if (i == 4)
                    `CHK("rx_sel", cf[2], serial_rx_sel)
                rd(`ADR(`PPC_IDX_PIN23 + i), 33'h0);
            end
        do_reset();
        ext_en <= 5'h1f;
        wr(`ADR(`PPC_IDX_PIN30), 32'hd);
        wr(`ADR(`PPC_IDX_PIN31), 32'h9);
        ext_val <= 5'h06;
        repeat (4) @(posedge pclk);
        rd(`ADR(`PPC_IDX_LEVEL), 33'h2);
        tick_64hz <= 1'b1;
        @(posedge pclk);
        tick_64hz <= 1'b0;
        repeat (3) @(posedge pclk);
        rd(`ADR(`PPC_IDX_LEVEL), 33'h6);
        rd(`ADR(`PPC_IDX_STATUS), 33'h6);
        `CHK("irq", 1'b0, irq)
        wr(`ADR(`PPC_IDX_MASK), 32'h2);
        rd(`ADR(`PPC_IDX_MASK), 33'h2);
        `CHK("irq", 1'b1, irq)
        wr(`ADR(`PPC_IDX_PIN30), 32'h5);
        repeat (3) @(posedge pclk);
        rd(`ADR(`PPC_IDX_LEVEL), 33'h4);
        wr(`ADR(`PPC_IDX_STATUS), 32'h6);
        rd(`ADR(`PPC_IDX_STATUS), 33'h0);
        @(posedge pclk);
        `CHK("irq", 1'b0, irq)
        rd(8'hfc, {1'b1, 32'h0});
        // Serial input on pin 3.3 follows the pad, far side drives 0
        wr(`ADR(`PPC_IDX_PIN33), 32'h6);
        @(posedge pclk);
        `CHK("rx_data", 1'b0, serial_rx_data)
        `CHK("rx_oe_n", 1'b1, pad_oe_n[4])
        conclude();
    end
endmodule
`default_nettype wire
